// file: verilog/scan_proc_pkg.sv
// Shared constants for the scan-driven filter and hex/text converter.
// Assumes one 20 MHz clock; all operands are unsigned 16-bit words.
package scan_proc_pkg;
   localparam int WORD_W = 16;
   localparam int CNT_W = 7;
   localparam logic [6:0] AVG_MAX_N = 7'h40;
   localparam logic [6:0] H2T_MAX_N = 7'h20;
   localparam logic [6:0] T2H_MAX_N = 7'h40;
   localparam int T2H_BUF_WORDS = 32;
   localparam logic [31:0] FL_SCALE = 32'h0000_2710;
   localparam logic [15:0] FL_MAX = 16'h270f;
   localparam logic [7:0] ASCII_DIGIT0 = 8'h30;
   localparam logic [7:0] ASCII_DIGIT9 = 8'h39;
   localparam logic [7:0] ASCII_UPPER_A = 8'h41;
   localparam logic [7:0] ASCII_UPPER_F = 8'h46;
   localparam logic [7:0] ALPHA_BASE = 8'h37;
   localparam int FIFO_DEPTH = 8;
   localparam logic [15:0] WORD_RST = 16'h0000;

   typedef enum logic [1:0] {
      OP_AVG = 2'b00,
      OP_LAG = 2'b01,
      OP_H2T = 2'b10,
      OP_T2H = 2'b11
   } op_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_AVG_SUM = 4'b0001,
      ST_AVG_DIV = 4'b0010,
      ST_H2T_READ = 4'b0011,
      ST_H2T_WR0 = 4'b0100,
      ST_H2T_WR1 = 4'b0101,
      ST_T2H_READ = 4'b0110,
      ST_T2H_EMIT = 4'b0111
   } state_t;
endpackage : scan_proc_pkg

// file: verilog/word_fifo.sv
// Small synchronous word FIFO with valid/ready on both sides.
// Assumes a single clock, synchronous reset and a common clock enable.
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic room_r, room_nxt;
   logic push, pop;

   always_comb begin
      push = in_valid && room_r;
      pop = out_valid && out_ready;
      wptr_nxt = wptr_r;
      rptr_nxt = rptr_r;
      if (push) begin
         wptr_nxt = (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
         rptr_nxt = (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // Registered room flag lets the source's ready come from a flop
      room_nxt = (cnt_nxt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
         room_r <= 1'b1;
      end else if (ce) begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r <= cnt_nxt;
         room_r <= room_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wptr_r] <= in_data;
      end
   end

   assign in_ready = room_r;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rptr_r];
endmodule : word_fifo

// file: verilog/scan_proc.sv
// Per-scan data processing: moving average, lag filter, hex-to-text and
// text-to-hex conversion. One command is one scan's execution.
// Assumes all inputs come from logic on clk; source words of the
// conversions arrive on the src stream, result words leave on dst.
`timescale 1ns/100ps
// Notes on behaviour
// [RL1] Enabled average writes mean of latest n samples, n from 1 to 64.
// [RL2] History sits in n table words; output's next word is write pointer.
// [RL3] Before n samples exist, divide partial sum by n, missing ones zero.
// [RL4] Enable low: no execution, result false; enable high: execute, true.
// [RL5] Lag output is (1-coef)*input plus coef*previous output.
// [RL6] Coefficient is operand/10000, operand clamped to 0..9999 first.
// [RL7] Lag filter keeps a work word after its output across scans.
// [RL8] Hex-to-text makes one ASCII byte per digit, 2n words from n.
// [RL9] Top digit of first source goes to low byte of first destination.
// [RL10] Digits 0-9 map to 30h-39h, 10-15 to 41h-46h; nothing else valid.
// [RL11] Index-modified hex-to-text source accepts only n of one.
// [RL12] Text-to-hex packs characters of n words (1..64) four per word.
// [RL13] Low byte of first source becomes top digit of first destination.
// [RL14] Any bad character: no conversion, result false, error flag set.
// [RL15] Error flag stays set until the user program clears it.
// [RL16] Results truncate to 16 bits; sums wide enough for 64 samples.
module scan_proc #(
   parameter int FIFO_W = 16,
   parameter int FIFO_D = scan_proc_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_enable,
   input wire logic [1:0] cmd_op,
   input wire logic [6:0] cmd_count,
   input wire logic cmd_indexed,
   input wire logic [15:0] cmd_sample,
   input wire logic [15:0] cmd_coef,
   input wire logic src_valid,
   input wire logic [15:0] src_data,
   output logic src_ready,
   output logic dst_valid,
   output logic [15:0] dst_data,
   input wire logic dst_ready,
   output logic res_valid,
   output logic res_ok,
   output logic res_bound_err,
   output logic [15:0] res_data,
   output logic [15:0] res_aux,
   input wire logic err_clear,
   output logic instruction_error_flag
);
   scan_proc_pkg::state_t state_r, state_nxt;
   logic [15:0] table_mem [64];
   logic [15:0] t2h_buf [scan_proc_pkg::T2H_BUF_WORDS];
   logic [6:0] n_r, n_nxt, fill_r, fill_nxt, idx_r, idx_nxt;
   logic [5:0] ptr_r, ptr_nxt;
   logic [21:0] sum_r, sum_nxt;
   logic [15:0] y_r, y_nxt, work_r, work_nxt, w_r, w_nxt;
   logic bad_r, bad_nxt;
   logic ready_r, ready_nxt;
   logic dv_r, dv_nxt;
   logic [15:0] dd_r, dd_nxt;
   logic rv_r, rv_nxt, rok_r, rok_nxt, rbe_r, rbe_nxt;
   logic [15:0] rd_r, rd_nxt, ra_r, ra_nxt;
   logic err_r, err_nxt;
   logic tab_we, buf_we;
   logic [15:0] buf_wdata;
   logic [4:0] buf_widx;
   logic f_valid, f_pop, f_in_ready;
   logic [15:0] f_data;
   logic [15:0] fl;
   logic [31:0] lag_num;
   logic [4:0] lo_d, hi_d;
   logic take, set_err;

   // ASCII character to {valid, digit}
   function automatic logic [4:0] txt2hex(input logic [7:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= scan_proc_pkg::ASCII_DIGIT0 &&
          c <= scan_proc_pkg::ASCII_DIGIT9) begin
         r = {1'b1, 4'(c - scan_proc_pkg::ASCII_DIGIT0)}; // [RL10]
      end else if (c >= scan_proc_pkg::ASCII_UPPER_A &&
                   c <= scan_proc_pkg::ASCII_UPPER_F) begin
         r = {1'b1, 4'(c - scan_proc_pkg::ALPHA_BASE)}; // [RL10]
      end
      return r;
   endfunction : txt2hex

   function automatic logic [7:0] hex2txt(input logic [3:0] d);
      logic [7:0] r;
      r = (d < 4'ha) ? scan_proc_pkg::ASCII_DIGIT0 + {4'h0, d}
                     : scan_proc_pkg::ALPHA_BASE + {4'h0, d}; // [RL10]
      return r;
   endfunction : hex2txt

   word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_src_fifo (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .in_valid(src_valid),
      .in_data(src_data),
      .in_ready(f_in_ready),
      .out_valid(f_valid),
      .out_data(f_data),
      .out_ready(f_pop)
   );

   always_comb begin
      state_nxt = state_r;
      n_nxt = n_r;
      fill_nxt = fill_r;
      idx_nxt = idx_r;
      ptr_nxt = ptr_r;
      sum_nxt = sum_r;
      y_nxt = y_r;
      work_nxt = work_r;
      w_nxt = w_r;
      bad_nxt = bad_r;
      dv_nxt = dv_r;
      dd_nxt = dd_r;
      rv_nxt = 1'b0;
      rok_nxt = rok_r;
      rbe_nxt = rbe_r;
      rd_nxt = rd_r;
      ra_nxt = ra_r;
      set_err = 1'b0;
      tab_we = 1'b0;
      buf_we = 1'b0;
      buf_wdata = 16'h0000;
      buf_widx = idx_r[5:1];
      f_pop = 1'b0;
      take = cmd_valid && ready_r;
      fl = (cmd_coef > scan_proc_pkg::FL_MAX) ? scan_proc_pkg::FL_MAX
                                             : cmd_coef; // [RL6]
      lag_num = (scan_proc_pkg::FL_SCALE - {16'h0000, fl}) *
                {16'h0000, cmd_sample} + {16'h0000, fl} * {16'h0000, y_r};
      lo_d = txt2hex(f_data[7:0]);
      hi_d = txt2hex(f_data[15:8]);
      case (state_r)
         scan_proc_pkg::ST_IDLE: begin
            if (take) begin
               rbe_nxt = 1'b0;
               if (!cmd_enable) begin
                  rv_nxt = 1'b1; // [RL4]
                  rok_nxt = 1'b0;
               end else begin
                  case (scan_proc_pkg::op_t'(cmd_op))
                     scan_proc_pkg::OP_AVG: begin
                        if (cmd_count == 7'h00 ||
                            cmd_count > scan_proc_pkg::AVG_MAX_N) begin
                           rv_nxt = 1'b1;
                           rok_nxt = 1'b0;
                           rbe_nxt = 1'b1;
                        end else begin
                           // Size change restarts the history
                           if (cmd_count != n_r) begin
                              fill_nxt = 7'h01; // [RL3]
                              tab_we = 1'b1;
                              ptr_nxt = (cmd_count == 7'h01) ? 6'h00
                                                              : 6'h01;
                           end else begin
                              tab_we = 1'b1; // [RL2]
                              if (fill_r != cmd_count) begin
                                 fill_nxt = fill_r + 7'h01;
                              end
                              ptr_nxt = (7'(ptr_r) + 7'h01 == cmd_count)
                                        ? 6'h00 : ptr_r + 6'h01; // [RL2]
                           end
                           n_nxt = cmd_count;
                           idx_nxt = 7'h00;
                           sum_nxt = 22'h000000;
                           state_nxt = scan_proc_pkg::ST_AVG_SUM;
                        end
                     end
                     scan_proc_pkg::OP_LAG: begin
                        y_nxt = 16'(lag_num / scan_proc_pkg::FL_SCALE);
                        // [RL5] [RL16]
                        work_nxt = 16'(lag_num % scan_proc_pkg::FL_SCALE);
                        // [RL7]
                        rv_nxt = 1'b1;
                        rok_nxt = 1'b1; // [RL4]
                        rd_nxt = 16'(lag_num / scan_proc_pkg::FL_SCALE);
                        ra_nxt = 16'(lag_num % scan_proc_pkg::FL_SCALE);
                     end
                     scan_proc_pkg::OP_H2T: begin
                        if (cmd_count == 7'h00 ||
                            cmd_count > scan_proc_pkg::H2T_MAX_N ||
                            (cmd_indexed && cmd_count != 7'h01)) begin
                           rv_nxt = 1'b1; // [RL11]
                           rok_nxt = 1'b0;
                           rbe_nxt = 1'b1;
                        end else begin
                           // Average history stays intact across conversions
                           idx_nxt = cmd_count;
                           state_nxt = scan_proc_pkg::ST_H2T_READ;
                        end
                     end
                     default: begin
                        if (cmd_count == 7'h00 ||
                            cmd_count > scan_proc_pkg::T2H_MAX_N) begin
                           rv_nxt = 1'b1;
                           rok_nxt = 1'b0;
                           rbe_nxt = 1'b1;
                        end else begin
                           w_nxt = {9'h000, cmd_count};
                           idx_nxt = 7'h00;
                           bad_nxt = 1'b0;
                           state_nxt = scan_proc_pkg::ST_T2H_READ;
                        end
                     end
                  endcase
               end
            end
         end
         scan_proc_pkg::ST_AVG_SUM: begin
            // Entries never written since the restart count as zero
            if (idx_r < fill_r) begin
               sum_nxt = sum_r + {6'h00, table_mem[idx_r[5:0]]}; // [RL3]
            end
            idx_nxt = idx_r + 7'h01;
            if (idx_r + 7'h01 == n_r) begin
               state_nxt = scan_proc_pkg::ST_AVG_DIV;
            end
         end
         scan_proc_pkg::ST_AVG_DIV: begin
            rv_nxt = 1'b1;
            rok_nxt = 1'b1; // [RL4]
            rd_nxt = 16'(sum_r / {15'h0000, n_r}); // [RL1] [RL16]
            ra_nxt = {10'h000, ptr_r}; // [RL2]
            state_nxt = scan_proc_pkg::ST_IDLE;
         end
         scan_proc_pkg::ST_H2T_READ: begin
            if (f_valid) begin
               f_pop = 1'b1;
               w_nxt = f_data;
               dv_nxt = 1'b1;
               dd_nxt = {hex2txt(f_data[11:8]), hex2txt(f_data[15:12])};
               // [RL8] [RL9]
               state_nxt = scan_proc_pkg::ST_H2T_WR0;
            end
         end
         scan_proc_pkg::ST_H2T_WR0: begin
            if (dst_ready) begin
               dd_nxt = {hex2txt(w_r[3:0]), hex2txt(w_r[7:4])}; // [RL9]
               state_nxt = scan_proc_pkg::ST_H2T_WR1;
            end
         end
         scan_proc_pkg::ST_H2T_WR1: begin
            if (dst_ready) begin
               dv_nxt = 1'b0;
               idx_nxt = idx_r - 7'h01;
               if (idx_r == 7'h01) begin
                  rv_nxt = 1'b1;
                  rok_nxt = 1'b1; // [RL4]
                  state_nxt = scan_proc_pkg::ST_IDLE;
               end else begin
                  state_nxt = scan_proc_pkg::ST_H2T_READ;
               end
            end
         end
         scan_proc_pkg::ST_T2H_READ: begin
            // The whole source is checked before any word leaves
            if (f_valid) begin
               f_pop = 1'b1;
               buf_we = 1'b1;
               buf_wdata = idx_r[0] ? {t2h_buf[buf_widx][15:8],
                                       lo_d[3:0], hi_d[3:0]}
                                    : {lo_d[3:0], hi_d[3:0], 8'h00};
               // [RL12] [RL13]
               bad_nxt = bad_r || !lo_d[4] || !hi_d[4]; // [RL14]
               idx_nxt = idx_r + 7'h01;
               if (idx_r + 7'h01 == w_r[6:0]) begin
                  idx_nxt = 7'h00;
                  if (bad_r || !lo_d[4] || !hi_d[4]) begin
                     rv_nxt = 1'b1;
                     rok_nxt = 1'b0; // [RL14]
                     set_err = 1'b1;
                     state_nxt = scan_proc_pkg::ST_IDLE;
                  end else begin
                     state_nxt = scan_proc_pkg::ST_T2H_EMIT;
                  end
               end
            end
         end
         scan_proc_pkg::ST_T2H_EMIT: begin
            if (!dv_r) begin
               dv_nxt = 1'b1;
               dd_nxt = t2h_buf[idx_r[4:0]];
            end else if (dst_ready) begin
               dv_nxt = 1'b0;
               idx_nxt = idx_r + 7'h01;
               if ({idx_r[5:0], 1'b1} >= w_r[6:0] - 7'h01 ||
                   idx_r + 7'h01 == {1'b0, w_r[6:1]} + {6'h00, w_r[0]}) begin
                  rv_nxt = 1'b1;
                  rok_nxt = 1'b1; // [RL4]
                  state_nxt = scan_proc_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = scan_proc_pkg::ST_IDLE;
         end
      endcase
      // Setting beats a clear arriving in the same cycle
      err_nxt = set_err || (err_r && !err_clear); // [RL15]
      ready_nxt = (state_nxt == scan_proc_pkg::ST_IDLE) && !rv_nxt;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= scan_proc_pkg::ST_IDLE;
         n_r <= 7'h00;
         fill_r <= 7'h00;
         idx_r <= 7'h00;
         ptr_r <= 6'h00;
         sum_r <= 22'h000000;
         y_r <= scan_proc_pkg::WORD_RST;
         work_r <= scan_proc_pkg::WORD_RST;
         w_r <= scan_proc_pkg::WORD_RST;
         bad_r <= 1'b0;
         ready_r <= 1'b0;
         dv_r <= 1'b0;
         dd_r <= scan_proc_pkg::WORD_RST;
         rv_r <= 1'b0;
         rok_r <= 1'b0;
         rbe_r <= 1'b0;
         rd_r <= scan_proc_pkg::WORD_RST;
         ra_r <= scan_proc_pkg::WORD_RST;
         err_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         n_r <= n_nxt;
         fill_r <= fill_nxt;
         idx_r <= idx_nxt;
         ptr_r <= ptr_nxt;
         sum_r <= sum_nxt;
         y_r <= y_nxt;
         work_r <= work_nxt;
         w_r <= w_nxt;
         bad_r <= bad_nxt;
         ready_r <= ready_nxt;
         dv_r <= dv_nxt;
         dd_r <= dd_nxt;
         rv_r <= rv_nxt;
         rok_r <= rok_nxt;
         rbe_r <= rbe_nxt;
         rd_r <= rd_nxt;
         ra_r <= ra_nxt;
         err_r <= err_nxt;
      end
   end

   // History and text buffers need no reset: fill_r masks stale history entries; each text word is written before it is read
   always_ff @(posedge clk) begin
      if (ce && tab_we) begin
         table_mem[(cmd_count != n_r) ? 6'h00 : ptr_r] <= cmd_sample; // [RL2]
      end
      if (ce && buf_we) begin
         t2h_buf[buf_widx] <= buf_wdata;
      end
   end

   assign cmd_ready = ready_r;
   assign src_ready = f_in_ready;
   assign dst_valid = dv_r;
   assign dst_data = dd_r;
   assign res_valid = rv_r;
   assign res_ok = rok_r;
   assign res_bound_err = rbe_r;
   assign res_data = rd_r;
   assign res_aux = ra_r;
   assign instruction_error_flag = err_r;
endmodule : scan_proc

// file: testbench/scan_proc_props.sv
// Concurrent checks on the ports of scan_proc.
// Assumes one clock and srst synchronous active high; bound below.
`timescale 1ns/100ps
module scan_proc_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic cmd_enable,
   input wire logic [1:0] cmd_op,
   input wire logic [6:0] cmd_count,
   input wire logic cmd_indexed,
   input wire logic dst_valid,
   input wire logic [15:0] dst_data,
   input wire logic dst_ready,
   input wire logic res_valid,
   input wire logic res_ok,
   input wire logic res_bound_err,
   input wire logic err_clear,
   input wire logic instruction_error_flag
);
   logic take;
   assign take = cmd_valid && cmd_ready && ce;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   AST_RES_PULSE: assert property (res_valid && ce |=> !res_valid)
      else $error("result strobe longer than one cycle");
   AST_READY_BACK: assert property (res_valid && ce |=> cmd_ready)
      else $error("not ready in the cycle after a result");
   AST_TAKE_BUSY: assert property (take |=> !cmd_ready)
      else $error("ready right after a command was taken");
   AST_OFF_FALSE: assert property (take && !cmd_enable |=>
      res_valid && !res_ok && !res_bound_err)
      else $error("disabled command did not answer false");
   AST_LAG_ONE: assert property (take && cmd_enable &&
      cmd_op == scan_proc_pkg::OP_LAG |=> res_valid && res_ok)
      else $error("lag result not one cycle after take");
   AST_AVG_FIVE: assert property (take && cmd_enable &&
      cmd_op == scan_proc_pkg::OP_AVG && cmd_count == 7'h05
      |=> !res_valid [*6] ##1 res_valid && res_ok)
      else $error("average of five not answered on time");
   AST_AVG_ZERO: assert property (take && cmd_enable &&
      cmd_op == scan_proc_pkg::OP_AVG && cmd_count == 7'h00
      |=> res_valid && res_bound_err && !res_ok)
      else $error("average size zero not refused");
   AST_IDX_BOUND: assert property (take && cmd_enable &&
      cmd_op == scan_proc_pkg::OP_H2T && cmd_indexed && cmd_count != 7'h01
      |=> res_valid && res_bound_err && !res_ok)
      else $error("indexed conversion with count above one accepted");
   AST_FLAG_STICKY: assert property (instruction_error_flag &&
      !err_clear |=> instruction_error_flag)
      else $error("error flag dropped without a clear");
   AST_FLAG_CAUSE: assert property ($rose(instruction_error_flag)
      |-> res_valid && !res_ok && !dst_valid)
      else $error("error flag rose without a failed conversion");
   AST_DST_HOLD: assert property (dst_valid && !dst_ready && ce
      |=> dst_valid && $stable(dst_data))
      else $error("destination word changed while stalled");
endmodule : scan_proc_props
bind scan_proc scan_proc_props u_props (.clk(clk), .srst(srst), .ce(ce),
   .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_enable(cmd_enable),
   .cmd_op(cmd_op), .cmd_count(cmd_count), .cmd_indexed(cmd_indexed),
   .dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
   .res_valid(res_valid), .res_ok(res_ok), .res_bound_err(res_bound_err),
   .err_clear(err_clear), .instruction_error_flag(instruction_error_flag));

// file: testbench/tb_scan_proc.sv
// Self-checking bench for scan_proc; inputs change at the falling edge.
// Assumes the checker binds itself from its own file.
`timescale 1ns/100ps
module tb_scan_proc;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_enable = 1'b0;
   logic [1:0] cmd_op = 2'b00;
   logic [6:0] cmd_count = 7'h00;
   logic cmd_indexed = 1'b0;
   logic [15:0] cmd_sample = 16'h0000;
   logic [15:0] cmd_coef = 16'h0000;
   logic src_valid = 1'b0;
   logic [15:0] src_data = 16'h0000;
   logic dst_ready = 1'b1;
   logic err_clear = 1'b0;
   logic cmd_ready, src_ready, dst_valid, res_valid, res_ok, res_bound_err;
   logic [15:0] dst_data, res_data, res_aux;
   logic instruction_error_flag;
   logic [15:0] sw[8];
   logic [15:0] ex[4];
   logic [15:0] dq[$];
   bit stall = 1'b0;
   int bad_count = 0;
   int checks_done = 0;
   scan_proc u_dut (.clk(clk), .srst(srst), .ce(ce), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_enable(cmd_enable), .cmd_op(cmd_op),
      .cmd_count(cmd_count), .cmd_indexed(cmd_indexed),
      .cmd_sample(cmd_sample), .cmd_coef(cmd_coef), .src_valid(src_valid),
      .src_data(src_data), .src_ready(src_ready), .dst_valid(dst_valid),
      .dst_data(dst_data), .dst_ready(dst_ready), .res_valid(res_valid),
      .res_ok(res_ok), .res_bound_err(res_bound_err), .res_data(res_data),
      .res_aux(res_aux), .err_clear(err_clear),
      .instruction_error_flag(instruction_error_flag));
   always #25 clk = ~clk;
   function automatic logic [7:0] txt(input logic [3:0] d);
      return (d < 4'ha) ? 8'h30 + 8'(d) : 8'h37 + 8'(d);
   endfunction : txt
   task automatic chk(input string nm, input logic [15:0] e,
         input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // Hold each source word for one edge; src_ready is checked, not waited for
   task automatic feed(input int n);
      for (int i = 0; i < n; i++) begin
         chk("src_ready", 16'h1, 16'(src_ready));
         src_valid = 1'b1;
         src_data = sw[i];
         @(negedge clk);
      end
      src_valid = 1'b0;
   endtask : feed
   // One scan's command; destination words are gathered until the result
   task automatic run(input logic en, input logic [1:0] op,
         input logic [6:0] n, input logic idx, input logic [15:0] x,
         input logic [15:0] c);
      int k;
      k = 0;
      dq.delete();
      while (cmd_ready !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      cmd_valid = 1'b1;
      cmd_enable = en;
      cmd_op = op;
      cmd_count = n;
      cmd_indexed = idx;
      cmd_sample = x;
      cmd_coef = c;
      @(negedge clk);
      cmd_valid = 1'b0;
      k = 0;
      while (res_valid !== 1'b1 && k < 400) begin
         dst_ready = stall ? 1'($urandom % 2) : 1'b1;
         if (dst_valid === 1'b1 && dst_ready) dq.push_back(dst_data);
         @(negedge clk);
         k++;
      end
      chk("res_valid", 16'h1, 16'(res_valid));
   endtask : run
   initial begin
      int av_x[8] = '{1000, 1005, 1009, 1012, 1007, 1004, 998, 994};
      longint y, num, cc, x, sum;
      void'($urandom(32'hcff4));
      repeat (16) @(negedge clk);
      srst = 1'b0;
      for (int op = 0; op < 4; op++) begin
         run(1'b0, 2'(op), 7'h01, 1'b0, 16'h1234, 16'h0000);
         chk("off_ok", 16'h0, 16'(res_ok));
      end
      for (int i = 0; i < 8; i++) begin
         run(1'b1, 2'b00, 7'h05, 1'b0, 16'(av_x[i]), 16'h0000);
         sum = 0;
         for (int j = 0; j <= i; j++) begin
            if (j + 5 > i) sum += av_x[j];
         end
         chk("avg5", 16'(sum / 5), res_data);
         chk("avg_ptr", 16'((i + 1) % 5), res_aux);
      end
      // Changing n restarts history, so a wide table starts from zeros
      sum = 0;
      for (int i = 0; i < 3; i++) begin
         x = $urandom % 65536;
         sum += x;
         run(1'b1, 2'b00, 7'h40, 1'b0, 16'(x), 16'h0000);
         chk("avg64", 16'(sum / 64), res_data);
      end
      x = $urandom % 65536;
      run(1'b1, 2'b00, 7'h01, 1'b0, 16'(x), 16'h0000);
      chk("avg1", 16'(x), res_data);
      run(1'b1, 2'b00, 7'h41, 1'b0, 16'h0001, 16'h0000);
      chk("avg_bound", 16'h1, 16'(res_bound_err));
      run(1'b1, 2'b00, 7'h00, 1'b0, 16'h0001, 16'h0000);
      chk("avg_zero", 16'h1, 16'(res_bound_err));
      y = 0;
      for (int i = 0; i < 12; i++) begin
         x = $urandom % 65536;
         cc = (i == 0) ? 65535 : (i == 1) ? 0 : (i == 2) ? 9999
            : $urandom % 12000;
         run(1'b1, 2'b01, 7'h01, 1'b0, 16'(x), 16'(cc));
         if (cc > 9999) cc = 9999;
         num = (10000 - cc) * x + cc * y;
         y = num / 10000;
         chk("lag_y", 16'(y), res_data);
         chk("lag_work", 16'(num % 10000), res_aux);
      end
      sw[0] = 16'($urandom);
      sw[1] = 16'($urandom);
      feed(2);
      stall = 1'b1;
      run(1'b1, 2'b10, 7'h02, 1'b0, 16'h0000, 16'h0000);
      chk("h2t_count", 16'h4, 16'(dq.size()));
      for (int i = 0; i < 4 && i < dq.size(); i++)
         chk("h2t", i[0] ? {txt(sw[i/2][3:0]), txt(sw[i/2][7:4])}
            : {txt(sw[i/2][11:8]), txt(sw[i/2][15:12])}, dq[i]);
      run(1'b1, 2'b10, 7'h02, 1'b1, 16'h0000, 16'h0000);
      chk("idx_bound", 16'h1, 16'(res_bound_err));
      run(1'b1, 2'b10, 7'h21, 1'b0, 16'h0000, 16'h0000);
      chk("h2t_bound", 16'h1, 16'(res_bound_err));
      // Fill the source buffer until it refuses, then drain with stalls
      for (int j = 0; j < 4; j++) begin
         ex[j] = 16'($urandom);
         sw[2*j] = {txt(ex[j][11:8]), txt(ex[j][15:12])};
         sw[2*j+1] = {txt(ex[j][3:0]), txt(ex[j][7:4])};
      end
      feed(8);
      chk("src_full", 16'h0, 16'(src_ready));
      run(1'b1, 2'b11, 7'h08, 1'b0, 16'h0000, 16'h0000);
      chk("t2h_ok", 16'h1, 16'(res_ok));
      for (int j = 0; j < 4; j++)
         chk("t2h", ex[j], (j < dq.size()) ? dq[j] : 16'hxxxx);
      stall = 1'b0;
      sw[0] = 16'h3130;
      sw[1] = ($urandom % 2) ? 16'h3a32 : 16'h4732;
      feed(2);
      run(1'b1, 2'b11, 7'h02, 1'b0, 16'h0000, 16'h0000);
      chk("bad_ok", 16'h0, 16'(res_ok));
      chk("bad_dst", 16'h0, 16'(dq.size()));
      @(negedge clk);
      chk("flag_set", 16'h1, 16'(instruction_error_flag));
      run(1'b1, 2'b01, 7'h01, 1'b0, 16'h0000, 16'h0000);
      chk("flag_hold", 16'h1, 16'(instruction_error_flag));
      // A frozen clock enable must ignore the clear as well
      ce = 1'b0;
      err_clear = 1'b1;
      @(negedge clk);
      chk("ce_freeze", 16'h1, 16'(instruction_error_flag));
      ce = 1'b1;
      @(negedge clk);
      err_clear = 1'b0;
      chk("flag_clr", 16'h0, 16'(instruction_error_flag));
      summarize();
   end
   // Well above the few hundred cycles the sequence needs
   initial begin
      #(50 * 20000);
      bad_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      summarize();
   end
endmodule : tb_scan_proc
